// File: inc/dacio_pkg.sv
// Function
// - Analog outputs decoded at offsets four to seven.
// - High-byte write updates the converter output.
// - Codes 0..4095, high nibble above low byte.
// - Eight-bit bus, upper word byte ignored.
// - Offset three write drives held digital outputs.
// - Offset three read returns digital input lines.
// - Digital outputs have no readback path.
// - Inputs captured at read start, held stable.
// - Input line two gates general counter.
// - Two counters cascade into 32-bit pacer.
// - Control bit zero gates pacer by line zero.
// - Pacer clocked on-board or from external clock.
// - Third counter is general-purpose 16-bit counter.
// - Conversion completion raises the interrupt request.
package dacio_pkg;

    // ========================================================
    // Register offsets
    localparam logic [3:0] OFS_ADC_START = 4'h0;
    localparam logic [3:0] OFS_DIGITAL = 4'h3;
    localparam logic [3:0] OFS_AO0_LOW = 4'h4;
    localparam logic [3:0] OFS_AO0_HIGH = 4'h5;
    localparam logic [3:0] OFS_AO1_LOW = 4'h6;
    localparam logic [3:0] OFS_AO1_HIGH = 4'h7;
    localparam logic [3:0] OFS_IRQ_CLEAR = 4'h8;
    localparam logic [3:0] OFS_PACER_CTRL = 4'ha;
    localparam logic [3:0] OFS_GP_LOW = 4'hc;
    localparam logic [3:0] OFS_GP_HIGH = 4'hd;
    localparam logic [3:0] OFS_PACER_BYTE = 4'he;
    localparam logic [3:0] OFS_PACER_LOAD = 4'hf;

    // ========================================================
    // Field positions and widths
    localparam int DAC_W = 12;
    localparam int CNT_W = 16;
    localparam int CTRL_GATE_BIT = 0;
    localparam int CTRL_EXTCLK_BIT = 1;
    localparam int CTRL_PACER_EN_BIT = 2;
    localparam int DIN_GP_GATE_BIT = 2;
    localparam int DIN_PACER_GATE_BIT = 0;

    // ========================================================
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DOUT_RST = 8'h00;
    localparam logic [11:0] DAC_RST = 12'h000;
    localparam logic [15:0] CNT_RST = 16'hffff;
    localparam logic [31:0] PACER_RST = 32'hffffffff;

    // ========================================================
    // Host bus request, one byte lane significant
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] data;
    } dacio_bus_t;

    typedef struct packed {
        logic upd0;
        logic upd1;
        logic [11:0] code0;
        logic [11:0] code1;
    } dacio_dac_t;

endpackage

// File: core/dacio_cnt.sv
`timescale 1ns/1ps
module dacio_cnt (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [15:0] load_val,
    input wire logic [15:0] reload,
    input wire logic en,
    output logic [15:0] count,
    output logic wrap
);

    logic [15:0] count_q;
    logic [15:0] count_d;

    // ========================================================
    // Down counter that reloads on the enabled tick after it reaches zero.
    always_comb begin
        count_d = count_q;
        if (load) begin
            count_d = load_val;
        end else if (en) begin
            if (count_q == 16'h0000) begin
                count_d = reload;
            end else begin
                count_d = count_q - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= dacio_pkg::CNT_RST;
        end else begin
            count_q <= count_d;
        end
    end

    assign count = count_q;
    assign wrap = en && !load && (count_q == 16'h0000);

endmodule

// File: core/dacio_top.sv
`timescale 1ns/1ps
module dacio_top (
    input wire logic clk,
    input wire logic rst,
    input wire dacio_pkg::dacio_bus_t bus_i,
    input wire logic [7:0] din,
    input wire logic ext_clk,
    input wire logic conv_done,
    output logic [7:0] rdata_q,
    output logic [7:0] dout_q,
    output dacio_pkg::dacio_dac_t dac_q,
    output logic gp_out_q,
    output logic conv_start_q,
    output logic irq_q
);

    // ========================================================
    // Address decode
    logic wr_dig;
    logic wr_lo0;
    logic wr_hi0;
    logic wr_lo1;
    logic wr_hi1;
    logic wr_ctrl;
    logic wr_gp_lo;
    logic wr_gp_hi;
    logic wr_pbyte;
    logic wr_pload;
    logic wr_start;
    logic wr_irqclr;
    logic [7:0] wbyte;

    // Only the low data byte is used on any write.
    assign wbyte = bus_i.data[7:0];

    always_comb begin
        wr_dig = bus_i.wr && bus_i.addr == dacio_pkg::OFS_DIGITAL;
        wr_lo0 = bus_i.wr && bus_i.addr == dacio_pkg::OFS_AO0_LOW;
        wr_hi0 = bus_i.wr && bus_i.addr == dacio_pkg::OFS_AO0_HIGH;
        wr_lo1 = bus_i.wr && bus_i.addr == dacio_pkg::OFS_AO1_LOW;
        wr_hi1 = bus_i.wr && bus_i.addr == dacio_pkg::OFS_AO1_HIGH;
        wr_ctrl = bus_i.wr && bus_i.addr == dacio_pkg::OFS_PACER_CTRL;
        wr_gp_lo = bus_i.wr && bus_i.addr == dacio_pkg::OFS_GP_LOW;
        wr_gp_hi = bus_i.wr && bus_i.addr == dacio_pkg::OFS_GP_HIGH;
        wr_pbyte = bus_i.wr && bus_i.addr == dacio_pkg::OFS_PACER_BYTE;
        wr_pload = bus_i.wr && bus_i.addr == dacio_pkg::OFS_PACER_LOAD;
        wr_start = bus_i.wr && bus_i.addr == dacio_pkg::OFS_ADC_START;
        wr_irqclr = bus_i.wr && bus_i.addr == dacio_pkg::OFS_IRQ_CLEAR;
    end

    // ========================================================
    // Analog output channels
    logic [7:0] lo0_q;
    logic [7:0] lo0_d;
    logic [7:0] lo1_q;
    logic [7:0] lo1_d;
    dacio_pkg::dacio_dac_t dac_d;

    always_comb begin
        lo0_d = lo0_q;
        lo1_d = lo1_q;
        dac_d = dac_q;
        dac_d.upd0 = 1'b0;
        dac_d.upd1 = 1'b0;
        if (wr_lo0) begin
            lo0_d = wbyte;
        end
        if (wr_lo1) begin
            lo1_d = wbyte;
        end
        if (wr_hi0) begin
            dac_d.code0 = {wbyte[3:0], lo0_q};
            dac_d.upd0 = 1'b1;
        end
        if (wr_hi1) begin
            dac_d.code1 = {wbyte[3:0], lo1_q};
            dac_d.upd1 = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lo0_q <= 8'h00;
            lo1_q <= 8'h00;
            dac_q <= '{1'b0, 1'b0, dacio_pkg::DAC_RST, dacio_pkg::DAC_RST};
        end else begin
            lo0_q <= lo0_d;
            lo1_q <= lo1_d;
            dac_q <= dac_d;
        end
    end

    // ========================================================
    // Digital port and read data
    logic [7:0] dout_d;
    logic [7:0] rdata_d;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [15:0] gp_count;

    always_comb begin
        dout_d = dout_q;
        ctrl_d = ctrl_q;
        if (wr_dig) begin
            dout_d = wbyte;
        end
        if (wr_ctrl) begin
            ctrl_d = wbyte;
        end
    end

    // Read data is captured once at the read strobe and then held, so the
    // host never sees input transitions during its cycle.
    always_comb begin
        rdata_d = rdata_q;
        if (bus_i.rd) begin
            case (bus_i.addr)
                dacio_pkg::OFS_DIGITAL: rdata_d = din;
                dacio_pkg::OFS_PACER_CTRL: rdata_d = ctrl_q;
                dacio_pkg::OFS_GP_LOW: rdata_d = gp_count[7:0];
                dacio_pkg::OFS_GP_HIGH: rdata_d = gp_count[15:8];
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout_q <= dacio_pkg::DOUT_RST;
            ctrl_q <= dacio_pkg::CTRL_RST;
            rdata_q <= 8'h00;
        end else begin
            dout_q <= dout_d;
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    // ========================================================
    // Counter clock source and gates
    logic ext_q;
    logic ext_prev_q;
    logic tick;
    logic gp_en;
    logic pacer_en;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_q <= ext_clk;
            ext_prev_q <= ext_q;
        end
    end

    // The system clock is the on-board 10 MHz source.
    always_comb begin
        if (ctrl_q[dacio_pkg::CTRL_EXTCLK_BIT]) begin
            tick = ext_q && !ext_prev_q;
        end else begin
            tick = 1'b1;
        end
        gp_en = tick && din[dacio_pkg::DIN_GP_GATE_BIT];
        pacer_en = tick && (!ctrl_q[dacio_pkg::CTRL_GATE_BIT] ||
            din[dacio_pkg::DIN_PACER_GATE_BIT]);
    end

    // ========================================================
    // General-purpose counter
    logic [7:0] gp_lo_q;
    logic [7:0] gp_lo_d;
    logic [15:0] gp_reload_q;
    logic [15:0] gp_reload_d;
    logic gp_wrap;

    always_comb begin
        gp_lo_d = gp_lo_q;
        gp_reload_d = gp_reload_q;
        if (wr_gp_lo) begin
            gp_lo_d = wbyte;
        end
        if (wr_gp_hi) begin
            gp_reload_d = {wbyte, gp_lo_q};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gp_lo_q <= 8'h00;
            gp_reload_q <= dacio_pkg::CNT_RST;
            gp_out_q <= 1'b0;
        end else begin
            gp_lo_q <= gp_lo_d;
            gp_reload_q <= gp_reload_d;
            gp_out_q <= gp_wrap;
        end
    end

    dacio_cnt u_gp (
        .clk(clk),
        .rst(rst),
        .load(wr_gp_hi),
        .load_val({wbyte, gp_lo_q}),
        .reload(gp_reload_q),
        .en(gp_en),
        .count(gp_count),
        .wrap(gp_wrap)
    );

    // ========================================================
    // Cascaded 32-bit pacer
    logic [31:0] pacer_reload_q;
    logic [31:0] pacer_reload_d;
    logic [15:0] p_lo_count;
    logic [15:0] p_hi_count;
    logic p_lo_wrap;
    logic p_hi_wrap;

    // Reload bytes shift in least significant first.
    always_comb begin
        pacer_reload_d = pacer_reload_q;
        if (wr_pbyte) begin
            pacer_reload_d = {wbyte, pacer_reload_q[31:8]};
        end
    end

    dacio_cnt u_pacer_lo (
        .clk(clk),
        .rst(rst),
        .load(wr_pload),
        .load_val(pacer_reload_q[15:0]),
        .reload(pacer_reload_q[15:0]),
        .en(pacer_en),
        .count(p_lo_count),
        .wrap(p_lo_wrap)
    );

    dacio_cnt u_pacer_hi (
        .clk(clk),
        .rst(rst),
        .load(wr_pload),
        .load_val(pacer_reload_q[31:16]),
        .reload(pacer_reload_q[31:16]),
        .en(p_lo_wrap),
        .count(p_hi_count),
        .wrap(p_hi_wrap)
    );

    // ========================================================
    // Conversion start and completion request
    logic conv_start_d;
    logic irq_d;

    always_comb begin
        conv_start_d = wr_start ||
            (p_hi_wrap && ctrl_q[dacio_pkg::CTRL_PACER_EN_BIT]);
        irq_d = irq_q;
        if (wr_irqclr) begin
            irq_d = 1'b0;
        end
        // A completion in the clearing cycle is kept.
        if (conv_done) begin
            irq_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pacer_reload_q <= dacio_pkg::PACER_RST;
            conv_start_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            pacer_reload_q <= pacer_reload_d;
            conv_start_q <= conv_start_d;
            irq_q <= irq_d;
        end
    end

    // ========================================================
    // Checks
    sequence s_low0;
        bus_i.wr && bus_i.addr == dacio_pkg::OFS_AO0_LOW;
    endsequence

    sequence s_high0;
        bus_i.wr && bus_i.addr == dacio_pkg::OFS_AO0_HIGH;
    endsequence

    a_dac0_pair: assert property (@(posedge clk) disable iff (rst)
        s_low0 ##1 s_high0 |=> dac_q.code0 ==
            {$past(bus_i.data[3:0]), $past(bus_i.data[7:0], 2)})
        else $error("Channel 0 code does not match its byte pair.");

    a_dac0_update: assert property (@(posedge clk) disable iff (rst)
        s_high0 |=> dac_q.upd0 &&
            dac_q.code0 == {$past(bus_i.data[3:0]), $past(lo0_q)})
        else $error("Channel 0 not updated by its high byte.");

    a_dac1_update: assert property (@(posedge clk) disable iff (rst)
        (bus_i.wr && bus_i.addr == dacio_pkg::OFS_AO1_HIGH) |=>
            dac_q.upd1 && dac_q.code1[11:8] == $past(bus_i.data[3:0]))
        else $error("Channel 1 not updated by its high byte.");

    a_low_hold: assert property (@(posedge clk) disable iff (rst)
        s_low0 |=> $stable(dac_q.code0) && !dac_q.upd0)
        else $error("Low byte write changed the channel 0 output.");

    a_dout_write: assert property (@(posedge clk) disable iff (rst)
        wr_dig |=> dout_q == $past(bus_i.data[7:0]) ##1
            (dout_q == $past(dout_q) || $past(wr_dig)))
        else $error("Digital outputs not taken from the low byte.");

    a_din_read: assert property (@(posedge clk) disable iff (rst)
        (bus_i.rd && bus_i.addr == dacio_pkg::OFS_DIGITAL) |=>
            rdata_q == $past(din))
        else $error("Digital read did not return the input lines.");

    a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
        !bus_i.rd |=> $stable(rdata_q))
        else $error("Read data moved outside a read strobe.");

    a_gp_gate: assert property (@(posedge clk) disable iff (rst)
        (!din[dacio_pkg::DIN_GP_GATE_BIT] && !wr_gp_hi) |=>
            $stable(gp_count))
        else $error("General counter moved while its gate was low.");

    a_pacer_gate: assert property (@(posedge clk) disable iff (rst)
        (ctrl_q[dacio_pkg::CTRL_GATE_BIT] &&
            !din[dacio_pkg::DIN_PACER_GATE_BIT] && !wr_pload) |=>
            $stable(p_lo_count) && $stable(p_hi_count))
        else $error("Pacer moved while gated off.");

    a_irq_set: assert property (@(posedge clk) disable iff (rst)
        conv_done |=> irq_q)
        else $error("Conversion completion did not raise the request.");

endmodule

// File: verif/dacio_host.sv
`timescale 1ns/1ps
// ==========
// Host processor on the byte-wide register bus.
module dacio_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output dacio_pkg::dacio_bus_t bus_o
);
    initial bus_o = '0;

    // A released bus drops both strobes and shows the inverse address and data, never stale data.
    task automatic access(input logic w, input logic [3:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        dacio_pkg::dacio_bus_t req;
        req.wr = w;
        req.rd = !w;
        req.addr = a;
        req.data = {8'($urandom), d};
        @(posedge clk);
        bus_o <= req;
        @(posedge clk);
        bus_o <= {2'b00, ~req.addr, ~req.data};
        @(negedge clk);
        q = rdata;
    endtask

    // Low and high byte go out on consecutive edges; the upper nibble of
    // the high byte carries noise on purpose.
    task automatic dac_load(input logic ch, input logic [11:0] code);
        dacio_pkg::dacio_bus_t req;
        req = '0;
        req.wr = 1'b1;
        req.addr = ch ? 4'h6 : 4'h4;
        req.data = {8'($urandom), code[7:0]};
        @(posedge clk);
        bus_o <= req;
        req.addr = ch ? 4'h7 : 4'h5;
        req.data = {8'($urandom), 4'($urandom), code[11:8]};
        @(posedge clk);
        bus_o <= req;
        @(posedge clk);
        bus_o <= {2'b00, ~req.addr, ~req.data};
        @(negedge clk);
    endtask
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk, rst, ext_clk, conv_done, ext_run;
    logic [7:0] din, rdata_q, dout_q, q, d;
    logic [11:0] c, shadow [2];
    logic [1:0] ext_cnt;
    dacio_pkg::dacio_bus_t bus;
    dacio_pkg::dacio_dac_t dac_q;
    logic gp_out_q, conv_start_q, irq_q;
    int mismatches, n_checks, n, i;

    dacio_top dacio_top_inst (.clk(clk), .rst(rst), .bus_i(bus), .din(din),
        .ext_clk(ext_clk), .conv_done(conv_done), .rdata_q(rdata_q),
        .dout_q(dout_q), .dac_q(dac_q), .gp_out_q(gp_out_q),
        .conv_start_q(conv_start_q), .irq_q(irq_q));
    dacio_host dacio_host_inst (.clk(clk), .rdata(rdata_q), .bus_o(bus));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // External clock rises every fourth cycle, and stands still when idle.
    always @(posedge clk) begin
        if (ext_run) begin
            ext_cnt <= ext_cnt + 2'd1;
            ext_clk <= ext_cnt[1];
        end
    end

    // ==========
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            mismatches++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        dacio_host_inst.access(1'b1, a, v, q);
    endtask

    task automatic rd(input logic [3:0] a);
        dacio_host_inst.access(1'b0, a, 8'h00, q);
    endtask

    function automatic int pacer_period(input logic [31:0] r, input int div);
        return (int'(r[15:0]) + 1) * (int'(r[31:16]) + 1) * div;
    endfunction

    // Cycles between two pulses of the chosen output, 600 if none.
    task automatic gap(input logic sel, output int g);
        int k;
        for (k = 0; k < 600 && (sel ? gp_out_q : conv_start_q) !== 1'b1; k++)
            @(negedge clk);
        @(negedge clk);
        for (g = 1; g < 600 && (sel ? gp_out_q : conv_start_q) !== 1'b1; g++)
            @(negedge clk);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results();
    end

    // ==========
    // Main sequence
    initial begin
        rst = 1'b1;
        din = 8'h00;
        ext_clk = 1'b0;
        ext_run = 1'b0;
        ext_cnt = 2'd0;
        conv_done = 1'b0;
        mismatches = 0;
        n_checks = 0;
        void'($urandom(32'h3c57));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("dac_q", dac_q, '0);
        check("dout_q", dout_q, dacio_pkg::DOUT_RST);
        check("irq_q", irq_q, 1'b0);
        rd(4'ha);
        check("ctrl", q, dacio_pkg::CTRL_RST);
        rd(4'h9);
        check("unmapped", q, 8'h00);
        $display("test reset done");

        shadow[0] = 12'h000;
        shadow[1] = 12'h000;
        wr(4'h4, 8'h5a);
        check("code0 low", dac_q.code0, shadow[0]);
        check("upd0 low", dac_q.upd0, 1'b0);
        wr(4'h6, 8'ha5);
        check("code1 low", dac_q.code1, shadow[1]);
        wr(4'h5, 8'hf3);
        check("code0 high", dac_q.code0, 12'h35a);
        check("code1 kept", dac_q.code1, shadow[1]);
        shadow[0] = 12'h35a;
        for (i = 4; i < 8; i++) begin
            rd(4'(i));
            check("wo read", q, 8'h00);
        end
        for (i = 0; i < 12; i++) begin
            c = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
            dacio_host_inst.dac_load(i[0], c);
            shadow[i[0]] = c;
            check("code0", dac_q.code0, shadow[0]);
            check("code1", dac_q.code1, shadow[1]);
            check("upd", {dac_q.upd1, dac_q.upd0}, 2'b01 << i[0]);
            @(negedge clk);
            check("upd end", {dac_q.upd1, dac_q.upd0}, 2'b00);
        end
        $display("test analog outputs done");

        for (i = 0; i < 8; i++) begin
            d = 8'($urandom);
            wr(4'h3, d);
            check("dout_q", dout_q, d);
            @(posedge clk);
            din <= ~d;
            rd(4'h3);
            check("din read", q, 8'(~d));
            check("dout held", dout_q, d);
        end
        fork
            rd(4'h3);
            begin
                @(posedge clk);
                @(posedge clk);
                din <= d;
            end
        join
        check("latched", q, 8'(~d));
        @(negedge clk);
        check("held", rdata_q, 8'(~d));
        $display("test digital port done");

        @(posedge clk);
        din <= 8'h00;
        wr(4'hc, 8'h34);
        wr(4'hd, 8'h12);
        rd(4'hc);
        check("gp low", q, 8'h34);
        rd(4'hc);
        check("gp hold", q, 8'h34);
        @(posedge clk);
        din <= 8'h04;
        repeat (5) @(posedge clk);
        din <= 8'h00;
        rd(4'hc);
        check("gp count", q, 8'h34 - 8'd5);
        rd(4'hd);
        check("gp high", q, 8'h12);
        wr(4'hc, 8'h03);
        wr(4'hd, 8'h00);
        @(posedge clk);
        din <= 8'h04;
        gap(1'b1, n);
        check("gp period", n, 4);
        $display("test general counter done");

        @(posedge clk);
        conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        @(negedge clk);
        check("irq set", irq_q, 1'b1);
        wr(4'h8, 8'h00);
        check("irq clear", irq_q, 1'b0);
        wr(4'h0, 8'h00);
        check("sw start", conv_start_q, 1'b1);
        $display("test conversion done");

        for (i = 0; i < 4; i++) begin
            wr(4'he, (i == 0) ? 8'h02 : (i == 2) ? 8'h01 : 8'h00);
        end
        wr(4'hf, 8'h00);
        wr(4'ha, 8'h04);
        gap(1'b0, n);
        check("pacer free", n, pacer_period(32'h00010002, 1));
        @(posedge clk);
        din <= 8'h00;
        wr(4'ha, 8'h05);
        rd(4'ha);
        check("ctrl rw", q, 8'h05);
        gap(1'b0, n);
        check("pacer gated", n, 600);
        @(posedge clk);
        din <= 8'h01;
        gap(1'b0, n);
        check("pacer open", n, pacer_period(32'h00010002, 1));
        wr(4'ha, 8'h06);
        ext_run <= 1'b1;
        gap(1'b0, n);
        check("pacer ext", n, pacer_period(32'h00010002, 4));
        ext_run <= 1'b0;
        gap(1'b0, n);
        check("ext still", n, 600);
        $display("test pacer done");
        results();
    end
endmodule
